// ==== verilog/uar_rx_recovery.sv ====
`timescale 1ns/100ps
// Function
// - error flags read as zero while acting as SPI host
// - no collision protection or multi-host in SPI host; double speed still follows the receive mode
// - SPI host: receive pin in on spi_data_in; no transmit pin or transfer clock pin here
// - SPI host has no client select output or multi-host input
// - oversample 16x in normal mode, 8x in double-speed mode
// - falling edge starts detection; first low sample is sample one
// - vote samples 8,9,10 or 4,5,6; two lows accept start bit
// - each data bit decided by three-sample majority
// - only the first stop bit is checked
// - low voted stop bit sets the character's frame error flag
// - next start accepted right after stop vote samples
// - vote centred on sample nine or sample five
// - receive mode value one selects double speed
module uar_rx_recovery
    import uar_pkg::*;
#(
    parameter int DATA_BITS = UAR_DATA_BITS_DEF
)
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // configuration
    input wire logic [1:0] receive_mode_select_in,
    input wire logic spi_host_in,
    // sample tick from the baud generator, one per oversample
    input wire logic sample_tick_in,
    // serial pins
    input wire logic rxd_in,
    input wire logic spi_data_in,
    // received character
    output uar_char_s char_out,
    output logic char_valid_out,
    output logic rx_busy_out
);
    uar_state_e state_r, state_nxt;
    logic [3:0] sample_r, sample_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [9:0] shift_r, shift_nxt;
    uar_char_s char_r, char_nxt;
    logic valid_r, valid_nxt;
    logic dbl_r, dbl_nxt;
    logic [1:0] sync1_r, sync2_r;
    logic line_r, line_nxt;
    logic line_in_sel;
    logic vote;
    logic vote_cap;
    logic [3:0] osr_last;
    logic [3:0] vote_first;

    // both pins synchronised before the mux, so a select change is safe
    assign line_in_sel = spi_host_in ? sync2_r[1] : sync2_r[0];

    // previous tick's sample; a per-clock copy would miss edges
    assign line_nxt = sample_tick_in ? line_in_sel : line_r;

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            sync1_r <= 2'h3;
            sync2_r <= 2'h3;
            line_r <= 1'b1;
        end
        else
        begin
            sync1_r <= {spi_data_in, rxd_in};
            sync2_r <= sync1_r;
            line_r <= line_nxt;
        end
    end

    function automatic logic [3:0] last_sample(input logic dbl);
        last_sample = dbl ? 4'(UAR_OSR_DOUBLE) : 4'(UAR_OSR_NORMAL - 1);
    endfunction : last_sample

    function automatic logic [3:0] first_vote(input logic dbl);
        first_vote = dbl ? 4'(UAR_VOTE_FIRST_DOUBLE)
            : 4'(UAR_VOTE_FIRST_NORMAL);
    endfunction : first_vote

    // samples numbered from 1; in normal mode 16 wraps to 0 in 4 bits
    assign osr_last = last_sample(dbl_r);
    assign vote_first = first_vote(dbl_r);

    assign vote_cap = sample_tick_in && (state_r != UAR_IDLE)
        && (sample_r == vote_first || sample_r == vote_first + 4'h1);

    uar_vote u_vote (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .clear_in(state_r == UAR_IDLE),
        .capture_in(vote_cap),
        .line_in(line_in_sel),
        .majority_out(vote)
    );

    always_comb
    begin
        state_nxt = state_r;
        sample_nxt = sample_r;
        bit_nxt = bit_r;
        shift_nxt = shift_r;
        char_nxt = char_r;
        valid_nxt = 1'b0;
        dbl_nxt = dbl_r;
        if (sample_tick_in)
        begin
            unique case (state_r)
                UAR_IDLE:
                begin
                    dbl_nxt = (receive_mode_select_in == UAR_MODE_DOUBLE);
                    if (line_r && !line_in_sel)
                    begin
                        state_nxt = UAR_START;
                        sample_nxt = 4'h2;
                    end
                end
                default:
                begin
                    sample_nxt = sample_r + 4'h1;
                    // normal wraps 15 to 0 (sample 16); double 8 to 1
                    if (sample_r == osr_last)
                        sample_nxt = dbl_r ? 4'h1 : 4'h0;
                    if (sample_r == vote_first + 4'h2)
                    begin
                        // third centre sample: decide now
                        unique case (state_r)
                            UAR_START:
                                if (vote)
                                    state_nxt = UAR_IDLE;
                                else
                                begin
                                    state_nxt = UAR_DATA;
                                    bit_nxt = UAR_BIT_RESET;
                                end
                            UAR_DATA:
                            begin
                                shift_nxt = {vote, shift_r[9:1]};
                                bit_nxt = bit_r + 4'h1;
                                if (bit_r == 4'(DATA_BITS - 1))
                                    state_nxt = UAR_STOP;
                            end
                            default:
                            begin
                                // extra stop bits fall into idle
                                char_nxt.data = shift_r >>
                                    (UAR_DATA_BITS_MAX - DATA_BITS);
                                char_nxt.frame_error_flag = !vote
                                    && !spi_host_in;
                                valid_nxt = 1'b1;
                                // both modes: edge hunt at next tick
                                state_nxt = UAR_IDLE;
                            end
                        endcase
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            state_r <= UAR_IDLE;
            sample_r <= UAR_SAMPLE_RESET;
            bit_r <= UAR_BIT_RESET;
            shift_r <= UAR_SHIFT_RESET;
            char_r <= '0;
            valid_r <= 1'b0;
            dbl_r <= 1'b0;
            char_out <= '0;
            char_valid_out <= 1'b0;
            rx_busy_out <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            sample_r <= sample_nxt;
            bit_r <= bit_nxt;
            shift_r <= shift_nxt;
            char_r <= char_nxt;
            valid_r <= valid_nxt;
            dbl_r <= dbl_nxt;
            char_out <= char_nxt;
            char_valid_out <= valid_nxt;
            rx_busy_out <= (state_nxt != UAR_IDLE);
        end
    end

    // no collision flag, select pin or arbitration logic
    // exists here by design; SPI host reception reuses this path
    logic unused_valid;
    assign unused_valid = valid_r;

endmodule : uar_rx_recovery

// ==== verilog/uar_pkg.sv ====
package uar_pkg;

    // receive mode selection codes
    localparam logic [1:0] UAR_MODE_NORMAL = 2'h0;
    localparam logic [1:0] UAR_MODE_DOUBLE = 2'h1;
    localparam logic [1:0] UAR_MODE_RESET = UAR_MODE_NORMAL;

    // oversampling figures per bit
    localparam int UAR_OSR_NORMAL = 16;
    localparam int UAR_OSR_DOUBLE = 8;
    localparam int UAR_VOTE_FIRST_NORMAL = 8;
    localparam int UAR_VOTE_FIRST_DOUBLE = 4;

    // frame layout defaults
    localparam int UAR_DATA_BITS_DEF = 8;
    localparam int UAR_DATA_BITS_MAX = 10;

    // reset values
    localparam logic [3:0] UAR_SAMPLE_RESET = 4'h0;
    localparam logic [3:0] UAR_BIT_RESET = 4'h0;
    localparam logic [9:0] UAR_SHIFT_RESET = 10'h000;

    typedef enum logic [1:0] {
        UAR_IDLE = 2'b00,
        UAR_START = 2'b01,
        UAR_DATA = 2'b11,
        UAR_STOP = 2'b10
    } uar_state_e;

    typedef struct packed {
        logic [9:0] data;
        logic frame_error_flag;
    } uar_char_s;

endpackage : uar_pkg

// ==== verilog/uar_vote.sv ====
`timescale 1ns/100ps
module uar_vote
    import uar_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // sample strobe and line
    input wire logic clear_in,
    input wire logic capture_in,
    input wire logic line_in,
    // vote result
    output logic majority_out
);
    logic [1:0] held_r;
    logic [1:0] held_nxt;

    // shift in the first two centre samples; combine them with the live third
    always_comb
    begin
        held_nxt = held_r;
        if (clear_in)
            held_nxt = 2'h0;
        else if (capture_in)
            held_nxt = {held_r[0], line_in};
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            held_r <= 2'h0;
        else
            held_r <= held_nxt;
    end

    // majority of the two held samples plus the live third
    assign majority_out = (held_r[1] & held_r[0]) | (held_r[1] & line_in)
        | (held_r[0] & line_in);

endmodule : uar_vote

// ==== verif/uar_rx_props.sv ====
`timescale 1ns/100ps
module uar_rx_props
    import uar_pkg::*;
(
    // watched ports
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [1:0] receive_mode_select_in,
    input wire logic spi_host_in,
    input wire logic sample_tick_in,
    input wire logic rxd_in,
    input wire logic spi_data_in,
    input uar_char_s char_out,
    input wire logic char_valid_out,
    input wire logic rx_busy_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    sequence s_start;
        $rose(rx_busy_out);
    endsequence
    sequence s_char;
        char_valid_out;
    endsequence
    AST_VALID_GAP: assert property (s_char |=> !char_valid_out[*8])
        else $error("valid pulses too close");
    AST_SPI_NO_FRAME_ERROR_FLAG: assert property ((s_char and spi_host_in) |->
        !char_out.frame_error_flag) else $error("error flag in spi host");
    AST_VALID_ON_TICK: assert property (s_char |->
        $past(sample_tick_in)) else $error("valid not after a tick");
    AST_BUSY_ON_TICK: assert property (s_start |->
        $past(sample_tick_in)) else $error("start not on a tick");
    AST_OUT_HELD: assert property (!char_valid_out |->
        $stable(char_out)) else $error("char changed without valid");
    AST_START_HOLD: assert property (s_start |->
        (rx_busy_out && !char_valid_out)[*8]) else $error("start cut short");
    AST_VALID_IN_FRAME: assert property (s_char |->
        $past(rx_busy_out)) else $error("valid outside a frame");
    AST_SPI_FRAME_ERROR_FLAG_SRC: assert property (
        (s_char and char_out.frame_error_flag) |-> !spi_host_in)
        else $error("error flag source wrong");
endmodule : uar_rx_props
bind uar_rx_recovery uar_rx_props u_uar_rx_props (.sys_clk_in, .rst_in,
    .receive_mode_select_in, .spi_host_in, .sample_tick_in, .rxd_in,
    .spi_data_in, .char_out, .char_valid_out, .rx_busy_out);

// ==== verif/uar_tx_model.sv ====
`timescale 1ns/100ps
module uar_tx_model
(
    // clock and oversample tick
    input wire logic sys_clk_in,
    input wire logic tick_in,
    // serial line, idles high
    output logic line_out
);
    initial line_out = 1'b1;
    task automatic hold(input logic lvl, input int n);
        line_out = lvl;
        repeat (n)
        begin
            do @(posedge sys_clk_in); while (tick_in !== 1'b1);
        end
        #10;
    endtask : hold
    // exact rate keeps inside tolerance
    task automatic send(input logic [9:0] d, input int nb,
        input logic stp, input int os);
        hold(1'b0, os);
        for (int i = 0; i < nb; i++) hold(d[i], os); // lsb first
        // line stays at stop level; caller raises it before any gap
        hold(stp, os); // one stop bit
    endtask : send
endmodule : uar_tx_model

// ==== verif/uar_rx_recovery_tb.sv ====
`timescale 1ns/100ps
module uar_rx_recovery_tb;
    import uar_pkg::*;
    logic clk, rst, spi, tick, line, valid, busy;
    logic [1:0] mode;
    uar_char_s chr;
    uar_char_s exp_q[$];
    int n_mismatch = 0;
    int n_checks = 0;
    int tc = 0;
    uar_rx_recovery u_uar_rx_recovery (.sys_clk_in(clk), .rst_in(rst),
        .receive_mode_select_in(mode), .spi_host_in(spi),
        .sample_tick_in(tick), .rxd_in(line | spi),
        .spi_data_in(line | !spi),
        .char_out(chr), .char_valid_out(valid), .rx_busy_out(busy));
    uar_tx_model u_uar_tx_model (.sys_clk_in(clk), .tick_in(tick),
        .line_out(line));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // tick every fourth clock, spaced as the design asks
    always @(posedge clk)
    begin
        tc <= (tc + 1) % 4;
        tick <= #10 (tc == 3);
    end
    task automatic check(input string nm, input logic [10:0] seen, exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    // look mid-cycle, away from the edge that launches the pulse
    always @(negedge clk)
        if (valid === 1'b1)
        begin
            check("pending", 11'(exp_q.size() != 0), 11'h1);
            if (exp_q.size() != 0)
                check("char", chr, exp_q.pop_front());
        end
    task automatic frame(input logic [1:0] md, input logic sp, stp,
        input int ic);
        logic [7:0] d;
        int os;
        d = 8'($urandom);
        os = (md == UAR_MODE_DOUBLE) ? UAR_OSR_DOUBLE : UAR_OSR_NORMAL;
        mode = md;
        spi = sp;
        if (ic > 0)
            u_uar_tx_model.hold(1'b1, ic);
        exp_q.push_back('{{2'h0, d}, !stp && !sp});
        u_uar_tx_model.send({2'h0, d}, UAR_DATA_BITS_DEF, stp, os);
    endtask : frame
    initial
    begin
        repeat (90000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end
    initial
    begin
        rst = 1'b1;
        mode = UAR_MODE_RESET;
        spi = 1'b0;
        tick = 1'b0;
        void'($urandom(32'h65ddc646));
        repeat (8) @(posedge clk);
        #10;
        rst = 1'b0;
        check("idle", 11'({valid, busy}), 11'h0);
        frame(2'h0, 1'b0, 1'b1, 32);
        frame(2'h0, 1'b0, 1'b1, 0); // back to back
        frame(2'h0, 1'b0, 1'b0, 16);
        frame(2'h1, 1'b0, 1'b1, 32);
        frame(2'h1, 1'b0, 1'b1, 0);
        frame(2'h1, 1'b0, 1'b0, 16);
        frame(2'h2, 1'b0, 1'b1, 32);
        frame(2'h0, 1'b1, 1'b0, 32);
        u_uar_tx_model.hold(1'b1, 32);
        u_uar_tx_model.hold(1'b0, 6); // short low rejected
        frame(2'h1, 1'b0, 1'b1, 32);
        u_uar_tx_model.hold(1'b1, 16);
        u_uar_tx_model.hold(1'b0, 3);
        for (int i = 0; i < 12; i++)
            frame(2'($urandom_range(1)), 1'b0, 1'($urandom), 16);
        u_uar_tx_model.hold(1'b1, 16);
        check("drained", 11'(exp_q.size()), 11'h0);
        check("busy", 11'(busy), 11'h0);
        report_and_stop();
    end
endmodule : uar_rx_recovery_tb
